/* design/spms_params.svh */
// Register map, field positions, reset values and counts of the serial port.
`ifndef SPMS_PARAMS_SVH
`define SPMS_PARAMS_SVH

`define SPMS_ADDR_CTRL  8'h00
`define SPMS_ADDR_STAT  8'h04
`define SPMS_ADDR_DATA  8'h08
`define SPMS_ADDR_MASK  8'h0C

`define SPMS_FLAG_DONE  0
`define SPMS_FLAG_MODE_FAULT_FLAG  1
`define SPMS_FLAG_WCOL  2
`define SPMS_FLAG_SSERR 3
`define SPMS_STAT_BUSY  4
`define SPMS_FLAG_W     4

`define SPMS_CTRL_RST   8'h00
`define SPMS_MASK_RST   4'h0
`define SPMS_RATE_NONE  3'h7
`define SPMS_LAST_EDGE  4'hF
`define SPMS_LAST_BIT   4'h7

`endif

/* design/spms_pkg.sv */
// Types shared by the serial port modules.
`default_nettype none
package spms_pkg;

    typedef enum logic [1:0] {
        SPMS_IDLE = 2'b00,
        SPMS_MRUN = 2'b01,
        SPMS_SRUN = 2'b10
    } spms_state_t;

    typedef struct packed {
        logic       select_disable;
        logic       en;
        logic       master;
        logic       clock_polarity;
        logic       clock_phase;
        logic [2:0] rate;
    } spms_ctrl_t;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
    } spms_sync_t;

    typedef struct packed {
        logic [6:0] cnt;
    } spms_rate_t;

endpackage
`default_nettype wire

/* design/spms_rate_gen.sv */
// Master bit-rate generator: one tick per half period of the serial clock.
`default_nettype none
`include "spms_params.svh"
module spms_rate_gen (
    input  wire logic  clk,
    input  wire logic  rst_n,
    spms_rate_if.gen   rif
);
    spms_pkg::spms_rate_t s_q;
    spms_pkg::spms_rate_t s_d;
    logic [6:0]           half_m1;
    logic                 hit;

    // A half period is 2^code peripheral clocks, so the full period divides by 2 to 128.
    assign half_m1  = 7'((8'h01 << rif.code) - 8'h01);
    assign hit      = rif.run && (rif.code != `SPMS_RATE_NONE) && (s_q.cnt == half_m1);
    assign rif.tick = hit;

    always_comb begin
        s_d = s_q;
        if (!rif.run || hit) begin
            s_d.cnt = 7'h00;
        end else begin
            s_d.cnt = 7'(s_q.cnt + 7'h01);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // spms_rate_gen
`default_nettype wire

/* design/spms_rate_if.sv */
// Link between the port core and its bit-rate generator.
`default_nettype none
interface spms_rate_if;
    logic [2:0] code;
    logic       run;
    logic       tick;
    modport gen  (input code, input run, output tick);
    modport user (output code, output run, input tick);
endinterface
`default_nettype wire

/* design/spms_sync.sv */
// Two-stage synchroniser for the slave-side serial inputs.
`default_nettype none
module spms_sync (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] d,
    output logic      [2:0] q
);
    spms_pkg::spms_sync_t s_q;
    spms_pkg::spms_sync_t s_d;

    always_comb begin
        s_d    = s_q;
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;
endmodule // spms_sync
`default_nettype wire

/* design/spms_top.sv */
// Byte-wide full-duplex serial port, master or slave, with an APB register slave.
// Notes on behaviour
// - Bytes shift most significant bit first, eight bits each.
// - Master drives the out line and samples return; slave does the reverse.
// - As master, produce exactly eight serial clock cycles per byte.
// - As slave, float the return line whenever select is high, unless phase and select-disable are both set.
// - As master, a low select raises mode fault against a second master.
// - As master with select disabled, never raise mode fault.
// - As slave with phase and select-disable set, count as always selected.
// - Clearing select-disable leaves a set mode fault untouched.
// - As slave with phase zero, a falling select starts the byte.
// - Rate generator only serves master mode; slave takes the far clock.
// - Rate codes 0 to 6 divide by 2 to 128; code 7 gives none.
// - Control bit chooses master when set, slave when cleared.
// - As master, a data write starts a transfer at once when idle, unless the rate code is 7.
// - At byte end set done flag and copy received byte together.
// - Mode fault sets its flag, interrupts and clears enable and master.
`default_nettype none
`include "spms_params.svh"
module spms_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe_n,
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe_n,
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe_n,
    input  wire logic        ss_n_i
);
    typedef struct packed {
        spms_pkg::spms_state_t        state;
        spms_pkg::spms_ctrl_t         ctrl;
        logic [3:0]                   mask;
        logic [`SPMS_FLAG_W-1:0]      flags;
        logic [7:0]                   tx_buf;
        logic                         tx_pend;
        logic [7:0]                   sh;
        logic [7:0]                   rx_sh;
        logic [7:0]                   rx_data;
        logic [3:0]                   cnt;
        logic                         sck;
        logic                         dout;
        logic                         sck_prev;
        logic                         ss_prev;
        logic [31:0]                  prdata;
    } spms_top_t;

    spms_top_t   s_q;
    spms_top_t   s_d;
    logic [2:0]  sync_q;
    logic        s_sck;
    logic        s_ss_n;
    logic        s_mosi;
    logic        tick;
    logic        sel;
    logic        fault;
    logic        done_p;
    logic        start_p;
    logic        wr_acc;
    logic        wr_data;
    logic        wr_stat;
    logic [7:0]  rx_new;

    spms_rate_if rif ();

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == `SPMS_ADDR_CTRL) || (a == `SPMS_ADDR_STAT) ||
                  (a == `SPMS_ADDR_DATA) || (a == `SPMS_ADDR_MASK);
    endfunction

    function automatic logic [31:0] rd_word(input logic [7:0] a, input spms_top_t s);
        rd_word = 32'h0000_0000;
        case (a)
            `SPMS_ADDR_CTRL: rd_word[7:0] = s.ctrl;
            `SPMS_ADDR_STAT: rd_word[`SPMS_STAT_BUSY:0] = {s.state != spms_pkg::SPMS_IDLE, s.flags};
            `SPMS_ADDR_DATA: rd_word[7:0] = s.rx_data;
            `SPMS_ADDR_MASK: rd_word[3:0] = s.mask;
            default:         rd_word = 32'h0000_0000;
        endcase
    endfunction

    // Slave inputs pass two flops before any edge detection.
    spms_sync u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({sck_i, ss_n_i, mosi_i}),
        .q     (sync_q)
    );
    assign {s_sck, s_ss_n, s_mosi} = sync_q;

    spms_rate_gen u_rate (
        .clk   (pclk),
        .rst_n (presetn),
        .rif   (rif)
    );
    assign rif.code = s_q.ctrl.rate;
    assign rif.run  = (s_q.state == spms_pkg::SPMS_MRUN);
    assign tick     = rif.tick;

    assign sel     = !s_ss_n || (s_q.ctrl.clock_phase && s_q.ctrl.select_disable);
    assign wr_acc  = psel && penable && pwrite && addr_ok(paddr);
    assign wr_data = wr_acc && (paddr == `SPMS_ADDR_DATA);
    assign wr_stat = wr_acc && (paddr == `SPMS_ADDR_STAT);
    assign fault   = s_q.ctrl.master && s_q.ctrl.en && !s_q.ctrl.select_disable && !s_ss_n;

    always_comb begin
        logic       lead;
        logic       trail;
        logic       bit_in;
        logic [7:0] v;
        lead    = 1'b0;
        trail   = 1'b0;
        bit_in  = 1'b0;
        v       = 8'h00;
        done_p  = 1'b0;
        start_p = 1'b0;
        rx_new  = s_q.rx_sh;
        s_d     = s_q;
        s_d.sck_prev = s_sck;
        s_d.ss_prev  = s_ss_n;
        // Read data is caught in the setup phase so the access phase answers from a flop.
        if (psel && !penable) begin
            s_d.prdata = rd_word(paddr, s_q);
        end
        if (wr_acc && paddr == `SPMS_ADDR_CTRL) begin
            s_d.ctrl = spms_pkg::spms_ctrl_t'(pwdata[7:0]);
            // Only the select error clears here; a pending mode fault stays for software to see.
            if (!s_d.ctrl.en) begin
                s_d.state = spms_pkg::SPMS_IDLE;
                s_d.cnt   = 4'h0;
                s_d.flags[`SPMS_FLAG_SSERR] = 1'b0;
            end
        end
        if (wr_stat) begin
            s_d.flags = s_q.flags & ~pwdata[`SPMS_FLAG_W-1:0];
        end
        if (wr_acc && paddr == `SPMS_ADDR_MASK) begin
            s_d.mask = pwdata[3:0];
        end
        if (wr_data) begin
            if (s_q.state != spms_pkg::SPMS_IDLE) begin
                s_d.flags[`SPMS_FLAG_WCOL] = 1'b1;
            end else if (s_q.ctrl.master && s_q.ctrl.en && s_q.ctrl.rate != `SPMS_RATE_NONE) begin
                start_p   = 1'b1;
                s_d.state = spms_pkg::SPMS_MRUN;
                s_d.cnt   = 4'h0;
                s_d.sck   = s_q.ctrl.clock_polarity;
                s_d.tx_pend = 1'b0;
                if (!s_q.ctrl.clock_phase) begin
                    s_d.dout = pwdata[7];
                    s_d.sh   = {pwdata[6:0], 1'b0};
                end else begin
                    s_d.sh   = pwdata[7:0];
                end
            end else begin
                s_d.tx_buf  = pwdata[7:0];
                s_d.tx_pend = 1'b1;
            end
        end
        unique case (s_q.state)
            spms_pkg::SPMS_IDLE: begin
                if (s_q.ctrl.master) begin
                    s_d.sck = s_q.ctrl.clock_polarity;
                end else if (s_q.ctrl.en && sel) begin
                    // Phase zero starts on the select edge; phase one on the first clock edge.
                    lead = (s_sck != s_q.sck_prev) && (s_sck != s_q.ctrl.clock_polarity);
                    if ((!s_q.ctrl.clock_phase && s_q.ss_prev && !s_ss_n) || (s_q.ctrl.clock_phase && lead)) begin
                        v = s_q.tx_pend ? s_q.tx_buf : s_q.sh;
                        s_d.tx_pend = 1'b0;
                        s_d.dout  = v[7];
                        s_d.sh    = {v[6:0], 1'b0};
                        s_d.state = spms_pkg::SPMS_SRUN;
                        s_d.cnt   = 4'h0;
                    end
                end
            end
            spms_pkg::SPMS_MRUN: begin
                bit_in = miso_i;
                if (tick) begin
                    s_d.sck = !s_q.sck;
                    lead    = (!s_q.sck) != s_q.ctrl.clock_polarity;
                    trail   = !lead;
                    s_d.cnt = 4'(s_q.cnt + 4'h1);
                    if (s_q.cnt == `SPMS_LAST_EDGE) begin
                        done_p    = 1'b1;
                        s_d.state = spms_pkg::SPMS_IDLE;
                    end
                end
            end
            spms_pkg::SPMS_SRUN: begin
                bit_in = s_mosi;
                lead   = (s_sck != s_q.sck_prev) && (s_sck != s_q.ctrl.clock_polarity);
                trail  = (s_sck != s_q.sck_prev) && (s_sck == s_q.ctrl.clock_polarity);
                if (!sel) begin
                    s_d.flags[`SPMS_FLAG_SSERR] = 1'b1;
                    s_d.state = spms_pkg::SPMS_IDLE;
                    lead      = 1'b0;
                    trail     = 1'b0;
                end
            end
            default: begin
                s_d.state = spms_pkg::SPMS_IDLE;
            end
        endcase
        if (s_q.state != spms_pkg::SPMS_IDLE) begin
            // Phase zero samples on leading edges, phase one on trailing edges.
            if (s_q.ctrl.clock_phase ? trail : lead) begin
                rx_new    = {s_q.rx_sh[6:0], bit_in};
                s_d.rx_sh = rx_new;
                if (s_q.state == spms_pkg::SPMS_SRUN) begin
                    s_d.cnt = 4'(s_q.cnt + 4'h1);
                    if (s_q.cnt == `SPMS_LAST_BIT) begin
                        done_p    = 1'b1;
                        s_d.state = spms_pkg::SPMS_IDLE;
                    end
                end
            end else if (s_q.ctrl.clock_phase ? lead : trail) begin
                s_d.dout = s_q.sh[7];
                s_d.sh   = {s_q.sh[6:0], 1'b0};
            end
        end
        if (done_p) begin
            s_d.flags[`SPMS_FLAG_DONE] = 1'b1;
            s_d.rx_data = rx_new;
        end
        // The fault is applied last so it beats a control write in the same cycle.
        if (fault) begin
            s_d.flags[`SPMS_FLAG_MODE_FAULT_FLAG] = 1'b1;
            s_d.ctrl.en     = 1'b0;
            s_d.ctrl.master = 1'b0;
            s_d.state       = spms_pkg::SPMS_IDLE;
            s_d.cnt         = 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q       <= '0;
            s_q.ctrl  <= spms_pkg::spms_ctrl_t'(`SPMS_CTRL_RST);
            s_q.mask  <= `SPMS_MASK_RST;
            s_q.state <= spms_pkg::SPMS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata    = s_q.prdata;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addr_ok(paddr);
    assign irq       = |(s_q.flags & s_q.mask);
    assign sck_o     = s_q.sck;
    assign mosi_o    = s_q.dout;
    assign miso_o    = s_q.dout;
    // A slave leaves clock and out line to the far master.
    assign sck_oe_n  = !(s_q.ctrl.en && s_q.ctrl.master);
    assign mosi_oe_n = !(s_q.ctrl.en && s_q.ctrl.master);
    assign miso_oe_n = !(s_q.ctrl.en && !s_q.ctrl.master && sel);

    // Helper counters read only by the checks below.
    logic [4:0] h_edges;
    logic [6:0] h_gap;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_edges <= 5'h00;
            h_gap   <= 7'h00;
        end else begin
            h_edges <= start_p ? 5'h00 : (s_d.sck != s_q.sck) ? 5'(h_edges + 5'h01) : h_edges;
            h_gap   <= (s_q.state != spms_pkg::SPMS_MRUN || tick) ? 7'h00 : 7'(h_gap + 7'h01);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_start;
        wr_data && s_q.state == spms_pkg::SPMS_IDLE && s_q.ctrl.master && s_q.ctrl.en &&
            s_q.ctrl.rate != `SPMS_RATE_NONE && !fault;
    endsequence

    sequence s_master_done;
        done_p && s_q.state == spms_pkg::SPMS_MRUN;
    endsequence

    chk_miso_float: assert property ((!s_q.ctrl.master && !sel) |-> miso_oe_n)
        else $error("Return line driven while deselected.");
    chk_fault_drops_mode: assert property ($rose(s_q.flags[`SPMS_FLAG_MODE_FAULT_FLAG]) |->
        (!s_q.ctrl.en && !s_q.ctrl.master && (irq || !s_q.mask[`SPMS_FLAG_MODE_FAULT_FLAG])))
        else $error("Mode fault left enable or master set.");
    chk_fault_cause: assert property ($rose(s_q.flags[`SPMS_FLAG_MODE_FAULT_FLAG]) |->
        $past(s_q.ctrl.master && !s_q.ctrl.select_disable && !s_ss_n))
        else $error("Mode fault without a low select in master mode.");
    chk_select_disable_keeps: assert property (($past(s_q.flags[`SPMS_FLAG_MODE_FAULT_FLAG]) && $fell(s_q.ctrl.select_disable) &&
        !$past(wr_stat)) |-> s_q.flags[`SPMS_FLAG_MODE_FAULT_FLAG])
        else $error("Mode fault lost when select-disable cleared.");
    chk_eight_clocks: assert property (s_master_done |=> h_edges == 5'h10)
        else $error("Master byte did not make sixteen clock edges.");
    chk_rate_spacing: assert property ((s_q.state == spms_pkg::SPMS_MRUN && tick) |->
        h_gap == 7'((8'h01 << s_q.ctrl.rate) - 8'h01))
        else $error("Serial clock edge spacing differs from rate code.");
    chk_no_rate_code: assert property ((s_q.ctrl.rate == `SPMS_RATE_NONE) |-> !tick)
        else $error("Rate code seven produced a tick.");
    chk_start_on_write: assert property (s_start |=>
        s_q.state == spms_pkg::SPMS_MRUN ##0 sck_o == s_q.ctrl.clock_polarity)
        else $error("Data write did not start a master transfer.");
    chk_msb_first: assert property ((s_start and !s_q.ctrl.clock_phase) |=> mosi_o == $past(pwdata[7]))
        else $error("First bit out was not the top bit.");
    chk_done_loads_rx: assert property (done_p |=>
        s_q.flags[`SPMS_FLAG_DONE] && s_q.rx_data == $past(rx_new))
        else $error("Done flag and received byte not updated together.");
    chk_slave_inputs: assert property (!s_q.ctrl.master |-> (sck_oe_n && mosi_oe_n && !tick))
        else $error("Slave drove clock or out line.");
    chk_forced_select: assert property ((s_q.ctrl.en && !s_q.ctrl.master && s_q.ctrl.clock_phase && s_q.ctrl.select_disable)
        |-> !miso_oe_n)
        else $error("Forced-select slave floated its return line.");
    chk_select_start: assert property ((s_q.ctrl.en && !s_q.ctrl.master && !s_q.ctrl.clock_phase && !fault &&
        s_q.state == spms_pkg::SPMS_IDLE && s_q.ss_prev && !s_ss_n && !wr_acc)
        |=> s_q.state == spms_pkg::SPMS_SRUN)
        else $error("Select fall did not start a phase-zero slave byte.");
    // Both lines are released together so a second master never fights this one.
    chk_fault_releases: assert property (fault |=>
        (s_q.state == spms_pkg::SPMS_IDLE && sck_oe_n && mosi_oe_n))
        else $error("Mode fault left the clock or out line driven.");
    chk_slave_count: assert property ((done_p && s_q.state == spms_pkg::SPMS_SRUN) |->
        s_q.cnt == `SPMS_LAST_BIT)
        else $error("Slave byte ended after a wrong number of bits.");
    chk_busy_write: assert property ((wr_data && s_q.state != spms_pkg::SPMS_IDLE) |=>
        s_q.flags[`SPMS_FLAG_WCOL])
        else $error("Data write while busy did not flag a collision.");
endmodule // spms_top
`default_nettype wire

/* verif/spms_slave_model.sv */
// Far-side serial slave that answers the port while it runs as master.
`default_nettype none
module spms_slave_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       ss_n,
    input  wire logic       clock_polarity,
    input  wire logic       clock_phase,
    input  wire logic [7:0] tx,
    output logic            miso,
    output logic      [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh;
    logic       drv;
    initial begin
        sh  = 8'h00;
        drv = 1'b0;
        rx  = 8'h00;
    end
    // A released line has no pull, so show the inverse of the last bit rather than a stale valid one.
    assign miso = ss_n ? ~drv : drv;
    always @(negedge ss_n) begin
        sh = clock_phase ? tx : {tx[6:0], 1'b0};
        if (!clock_phase) begin
            drv = tx[7];
        end
    end
    always @(sck) begin
        if (!ss_n) begin
            if ((sck != clock_polarity) ^ clock_phase) begin
                rx = {rx[6:0], mosi};
            end else begin
                drv = sh[7];
                sh  = {sh[6:0], 1'b0};
            end
        end
    end
endmodule // spms_slave_model
`default_nettype wire

/* verif/spms_top_test.sv */
// Self-checking bench for the serial port in master and slave roles.
`default_nettype none
`include "spms_params.svh"
`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("[FAIL] t=%0t got %0h exp %0h", $time, (got), (exp)); \
    end \
end
module spms_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdat;
    logic        pready, pslverr, irq, rerr;
    logic        sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
    logic        sck_d = 1'b0, mosi_d = 1'b0, ss_d = 1'b1, m_ss_n = 1'b1;
    logic        m_clock_polarity = 1'b0, m_clock_phase = 1'b0, sck_prev = 1'b0;
    logic        sck_w, mosi_w, miso_w, m_miso;
    logic [7:0]  m_tx = 8'h00;
    logic [7:0]  m_rx;
    int          errors = 0, comparisons = 0, cyc = 0, last = 0, per = 0, rises = 0;

    always #2 pclk = ~pclk;
    assign sck_w  = !sck_oe_n  ? sck_o  : sck_d;
    assign mosi_w = !mosi_oe_n ? mosi_o : mosi_d;
    assign miso_w = !miso_oe_n ? miso_o : m_miso;

    // Serial clock period is measured between rising edges while the port drives the clock.
    always @(posedge pclk) begin
        cyc++;
        if (sck_o && !sck_prev && !sck_oe_n) begin
            rises++;
            per  = cyc - last;
            last = cyc;
        end
        sck_prev = sck_o;
    end

    spms_top spms_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe_n(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .ss_n_i(ss_d));

    spms_slave_model spms_slave_model_i (.sck(sck_w), .mosi(mosi_w), .ss_n(m_ss_n), .clock_polarity(m_clock_polarity),
        .clock_phase(m_clock_phase), .tx(m_tx), .miso(m_miso), .rx(m_rx));

    task automatic report_and_stop;
        $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            report_and_stop();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, `SPMS_ADDR_STAT, 32'h0);
            n++;
        end while (rdat[`SPMS_STAT_BUSY] !== 1'b0 && n < 3000);
        if (n >= 3000) begin
            errors++;
            report_and_stop();
        end
    endtask

    task automatic t_reset;
        apb(1'b0, `SPMS_ADDR_CTRL, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b0, `SPMS_ADDR_STAT, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b0, `SPMS_ADDR_MASK, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b0, 8'h10, 32'h0);
        `CHK({rerr, rdat}, 33'h100000000)
        `CHK({irq, sck_oe_n, mosi_oe_n, miso_oe_n}, 4'h7)
        $display("test reset done");
    endtask

    task automatic t_master(input logic [2:0] r, input logic [7:0] tx, input logic [7:0] back);
        m_clock_polarity <= r[1];
        m_clock_phase <= r[0];
        m_tx   <= back;
        apb(1'b1, `SPMS_ADDR_MASK, 32'h1);
        apb(1'b1, `SPMS_ADDR_CTRL, {24'h0, 3'b011, r[1], r[0], r});
        // The clock settles to its new idle level before the far slave is selected.
        tick(3);
        m_ss_n <= 1'b0;
        rises = 0;
        apb(1'b1, `SPMS_ADDR_DATA, {24'h0, tx});
        // A second write lands while busy and must not reach the line.
        apb(1'b1, `SPMS_ADDR_DATA, {24'h0, ~tx});
        wait_idle();
        `CHK(rdat[3:0], 4'h5)
        `CHK(irq, 1'b1)
        `CHK(rises, 8)
        `CHK(per, 2 << r)
        `CHK(m_rx, tx)
        apb(1'b0, `SPMS_ADDR_DATA, 32'h0);
        `CHK(rdat[7:0], back)
        apb(1'b1, `SPMS_ADDR_STAT, 32'hF);
        tick(1);
        `CHK(irq, 1'b0)
        m_ss_n <= 1'b1;
        apb(1'b1, `SPMS_ADDR_CTRL, 32'h0);
        $display("test master rate %0d done", r);
    endtask

    task automatic t_norate;
        apb(1'b1, `SPMS_ADDR_CTRL, 32'h67);
        rises = 0;
        apb(1'b1, `SPMS_ADDR_DATA, 32'hA5);
        tick(40);
        apb(1'b0, `SPMS_ADDR_STAT, 32'h0);
        `CHK(rdat[4:0], 5'h0)
        `CHK(rises, 0)
        apb(1'b1, `SPMS_ADDR_CTRL, 32'h0);
        $display("test unused rate done");
    endtask

    task automatic t_fault;
        apb(1'b1, `SPMS_ADDR_MASK, 32'h2);
        apb(1'b1, `SPMS_ADDR_CTRL, 32'h60);
        ss_d <= 1'b0;
        tick(6);
        apb(1'b0, `SPMS_ADDR_STAT, 32'h0);
        `CHK(rdat[1], 1'b1)
        `CHK(irq, 1'b1)
        apb(1'b0, `SPMS_ADDR_CTRL, 32'h0);
        `CHK(rdat[7:0], 8'h00)
        ss_d <= 1'b1;
        apb(1'b1, `SPMS_ADDR_CTRL, 32'h80);
        apb(1'b1, `SPMS_ADDR_CTRL, 32'h00);
        apb(1'b0, `SPMS_ADDR_STAT, 32'h0);
        `CHK(rdat[1], 1'b1)
        apb(1'b1, `SPMS_ADDR_MASK, 32'h0);
        tick(1);
        `CHK(irq, 1'b0)
        apb(1'b1, `SPMS_ADDR_STAT, 32'h2);
        apb(1'b1, `SPMS_ADDR_MASK, 32'h2);
        apb(1'b0, `SPMS_ADDR_STAT, 32'h0);
        `CHK({irq, rdat[1]}, 2'b00)
        apb(1'b1, `SPMS_ADDR_CTRL, 32'hE0);
        ss_d <= 1'b0;
        tick(6);
        apb(1'b0, `SPMS_ADDR_STAT, 32'h0);
        `CHK(rdat[1], 1'b0)
        apb(1'b0, `SPMS_ADDR_CTRL, 32'h0);
        `CHK(rdat[7:0], 8'hE0)
        ss_d <= 1'b1;
        apb(1'b1, `SPMS_ADDR_CTRL, 32'h0);
        $display("test mode fault done");
    endtask

    // The bench plays the far master; half periods of four cycles respect the slave's speed limit.
    task automatic t_slave(input logic clock_phase, input logic select_disable, input int nb, input logic [7:0] tx,
                           input logic [7:0] mo);
        logic [7:0] got;
        got = 8'h00;
        apb(1'b1, `SPMS_ADDR_CTRL, {24'h0, select_disable, 2'b10, 1'b0, clock_phase, 3'h0});
        apb(1'b1, `SPMS_ADDR_DATA, {24'h0, tx});
        tick(4);
        `CHK(miso_oe_n, !select_disable)
        `CHK(sck_oe_n, 1'b1)
        if (!select_disable) begin
            ss_d <= 1'b0;
        end
        tick(4);
        for (int i = 7; i > 7 - nb; i--) begin
            if (!clock_phase) mosi_d <= mo[i];
            tick(4);
            if (!clock_phase) got[i] = miso_w;
            sck_d <= 1'b1;
            if (clock_phase) mosi_d <= mo[i];
            tick(4);
            if (clock_phase) got[i] = miso_w;
            sck_d <= 1'b0;
        end
        tick(8);
        ss_d <= 1'b1;
        tick(6);
        apb(1'b0, `SPMS_ADDR_STAT, 32'h0);
        if (nb == 8) begin
            `CHK(got, tx)
            `CHK(rdat[3:0], 4'h1)
            apb(1'b0, `SPMS_ADDR_DATA, 32'h0);
            `CHK(rdat[7:0], mo)
        end else begin
            `CHK(rdat[3], 1'b1)
        end
        `CHK(miso_oe_n, !select_disable)
        apb(1'b1, `SPMS_ADDR_STAT, 32'hF);
        apb(1'b1, `SPMS_ADDR_CTRL, 32'h0);
        $display("test slave phase %0d disable %0d bits %0d done", clock_phase, select_disable, nb);
    endtask

    initial begin
        tick(4);
        presetn <= 1'b1;
        t_reset();
        for (int r = 0; r < 7; r++) begin
            t_master(r[2:0], 8'hA5 ^ 8'(r), 8'h3C ^ 8'(r << 4));
        end
        t_norate();
        t_fault();
        t_slave(1'b0, 1'b0, 8, 8'h5A, 8'hC3);
        t_slave(1'b1, 1'b0, 8, 8'h96, 8'h3D);
        t_slave(1'b1, 1'b1, 8, 8'hE1, 8'h7E);
        t_slave(1'b0, 1'b0, 3, 8'h0F, 8'hF0);
        report_and_stop();
    end
endmodule // spms_top_test
`default_nettype wire
